// ### design/preload_pkg.sv
package preload_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int CELL_COUNT = 10;
	localparam int REG_COUNT  = 2 * CELL_COUNT;

	// ----------------------------------------------------------------
	// apb register map
	// ----------------------------------------------------------------
	localparam logic [11:0] REG0_OFFSET    = 12'h000; // register 0 bank
	localparam logic [11:0] REG1_OFFSET    = 12'h004; // register 1 bank
	localparam logic [11:0] POLARITY_OFFSET = 12'h008; // output polarity
	localparam logic [11:0] NEXT0_OFFSET   = 12'h00C; // next state, bank 0
	localparam logic [11:0] NEXT1_OFFSET   = 12'h010; // next state, bank 1
	localparam logic [11:0] STATUS_OFFSET  = 12'h014; // status

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CELL_COUNT-1:0] CELL_CLEAR     = 10'h000;
	localparam logic [CELL_COUNT-1:0] POLARITY_RESET = 10'h000;
	localparam logic [31:0]           DATA_ZERO      = 32'h00000000;

	// ----------------------------------------------------------------
	// power-up clear timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS               = 5000;
	localparam int POWERUP_CLEAR_INTERVAL_NS   = 1000;
	localparam int POWERUP_CLEAR_CYCLES =
		(POWERUP_CLEAR_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [7:0] POWERUP_CLEAR_LAST = 8'(POWERUP_CLEAR_CYCLES - 1);

	// status bit positions
	localparam int STATUS_BUSY_BIT    = 0;
	localparam int STATUS_PRELOAD_BIT = 1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                  enable; // forced-load state
		logic                  select; // 0 picks register 0
		logic [CELL_COUNT-1:0] level;  // i/o pin levels
	} preload_type;

	typedef enum logic [0:0] {
		PU_CLEARING,
		PU_RUN
	} pu_state_type;

endpackage : preload_pkg

// ### design/reg_cell.sv
module reg_cell
	import preload_pkg::*;
(
	// clock and power-up clear
	input  wire logic clk_i,
	input  wire logic clear_i,
	// forced load
	input  wire logic load_en_i,
	input  wire logic load_sel_i,
	input  wire logic load_level_i,
	// normal operation
	input  wire logic tick_i,
	input  wire logic next0_i,
	input  wire logic next1_i,
	// state
	output logic      reg0_o,
	output logic      reg1_o
);

	logic reg0_r;
	logic reg0_nxt;
	logic reg1_r;
	logic reg1_nxt;

	// next values: clear, then forced load, then normal update
	always_comb begin
		reg0_nxt = reg0_r;
		reg1_nxt = reg1_r;
		if (clear_i) begin
			reg0_nxt = 1'b0;
			reg1_nxt = 1'b0;
		end else if (load_en_i) begin
			// pin level loads as is, polarity not applied
			if (load_sel_i) begin
				reg1_nxt = load_level_i;
			end else begin
				reg0_nxt = load_level_i;
			end
		end else if (tick_i) begin
			reg0_nxt = next0_i;
			reg1_nxt = next1_i;
		end
	end

	// register pair
	always_ff @(posedge clk_i) begin
		reg0_r <= reg0_nxt;
		reg1_r <= reg1_nxt;
	end

	assign reg0_o = reg0_r;
	assign reg1_o = reg1_r;

endmodule : reg_cell

// ### design/preload_top.sv
// How it works
// - ten cells, two flip-flops each, twenty total
// - forced-load state loads high or low
// - pin level sets register, polarity ignored
// - clock pulse captures pins into selected register
// - select low writes reg 0, high reg 1
// - power-up clears every register low
// - outputs show cleared value through polarity
//
// Our own choices: the APB interface to the registers and the register offsets.
module preload_top
	import preload_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// apb slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// test fixture pins
	input  wire logic                  preload_en_i,
	input  wire logic                  select_i,
	input  wire logic                  clock_term_i,
	input  wire logic [CELL_COUNT-1:0] io_level_i,
	// output pins
	output logic      [CELL_COUNT-1:0] out_pin_o,
	output logic                       clearing_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	preload_type pins_meta_r;
	preload_type pins_sync_r;
	logic        clk_meta_r;
	logic        clk_sync_r;
	logic        clk_prev_r;

	// two stages per pin before any logic looks at it
	always_ff @(posedge clk_i) begin
		pins_meta_r <= '{enable: preload_en_i, select: select_i, level: io_level_i};
		pins_sync_r <= pins_meta_r;
		clk_meta_r  <= clock_term_i;
		clk_sync_r  <= clk_meta_r;
		clk_prev_r  <= clk_sync_r;
	end

	// rising edge of the synchronised clock term
	logic clk_rise;
	assign clk_rise = clk_sync_r & ~clk_prev_r;

	// ----------------------------------------------------------------
	// power-up clear sequencer
	// ----------------------------------------------------------------
	pu_state_type pu_state_r;
	pu_state_type pu_state_nxt;
	logic [7:0]   pu_count_r;
	logic [7:0]   pu_count_nxt;

	// hold the clear for the whole interval after reset
	always_comb begin
		pu_state_nxt = pu_state_r;
		pu_count_nxt = pu_count_r;
		unique case (pu_state_r)
			PU_CLEARING: begin
				if (pu_count_r == POWERUP_CLEAR_LAST) begin
					pu_state_nxt = PU_RUN;
				end else begin
					pu_count_nxt = pu_count_r + 8'h01;
				end
			end
			PU_RUN: begin
				pu_count_nxt = pu_count_r;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pu_state_r <= PU_CLEARING;
			pu_count_r <= 8'h00;
		end else begin
			pu_state_r <= pu_state_nxt;
			pu_count_r <= pu_count_nxt;
		end
	end

	// clear holds during reset and the whole interval
	logic clear;
	assign clear = rst_i | (pu_state_r == PU_CLEARING);

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic [CELL_COUNT-1:0] polarity_r;
	logic [CELL_COUNT-1:0] polarity_nxt;
	logic [CELL_COUNT-1:0] next0_r;
	logic [CELL_COUNT-1:0] next0_nxt;
	logic [CELL_COUNT-1:0] next1_r;
	logic [CELL_COUNT-1:0] next1_nxt;
	logic [31:0]           prdata_r;
	logic [31:0]           prdata_nxt;
	logic                  slverr;
	logic [CELL_COUNT-1:0] bank0;
	logic [CELL_COUNT-1:0] bank1;
	logic                  access;
	logic                  mapped;

	assign access = psel_i & penable_i;
	assign mapped = (paddr_i == REG0_OFFSET) | (paddr_i == REG1_OFFSET)
		| (paddr_i == POLARITY_OFFSET) | (paddr_i == NEXT0_OFFSET)
		| (paddr_i == NEXT1_OFFSET) | (paddr_i == STATUS_OFFSET);

	// decode writes and build read data
	always_comb begin
		polarity_nxt = polarity_r;
		next0_nxt    = next0_r;
		next1_nxt    = next1_r;
		prdata_nxt   = DATA_ZERO;
		if (psel_i & ~penable_i & ~pwrite_i) begin
			unique case (paddr_i)
				REG0_OFFSET:     prdata_nxt[CELL_COUNT-1:0] = bank0;
				REG1_OFFSET:     prdata_nxt[CELL_COUNT-1:0] = bank1;
				POLARITY_OFFSET: prdata_nxt[CELL_COUNT-1:0] = polarity_r;
				NEXT0_OFFSET:    prdata_nxt[CELL_COUNT-1:0] = next0_r;
				NEXT1_OFFSET:    prdata_nxt[CELL_COUNT-1:0] = next1_r;
				STATUS_OFFSET: begin
					prdata_nxt[STATUS_BUSY_BIT]    = clear;
					prdata_nxt[STATUS_PRELOAD_BIT] = pins_sync_r.enable;
				end
				default:         prdata_nxt = DATA_ZERO;
			endcase
		end else if (access) begin
			prdata_nxt = prdata_r;
		end
		if (access & pwrite_i) begin
			unique case (paddr_i)
				POLARITY_OFFSET: polarity_nxt = pwdata_i[CELL_COUNT-1:0];
				NEXT0_OFFSET:    next0_nxt    = pwdata_i[CELL_COUNT-1:0];
				NEXT1_OFFSET:    next1_nxt    = pwdata_i[CELL_COUNT-1:0];
				default:         polarity_nxt = polarity_r;
			endcase
		end
	end

	assign slverr = access & ~mapped;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			polarity_r <= POLARITY_RESET;
			next0_r    <= CELL_CLEAR;
			next1_r    <= CELL_CLEAR;
			prdata_r   <= DATA_ZERO;
		end else begin
			polarity_r <= polarity_nxt;
			next0_r    <= next0_nxt;
			next1_r    <= next1_nxt;
			prdata_r   <= prdata_nxt;
		end
	end

	// zero-wait slave, error on unmapped address
	assign pready_o  = 1'b1;
	assign pslverr_o = slverr;
	assign prdata_o  = prdata_r;

	// ----------------------------------------------------------------
	// register pairs
	// ----------------------------------------------------------------
	logic load_en;
	logic tick;

	// capture on a clock term pulse inside the forced-load state
	assign load_en = pins_sync_r.enable & clk_rise & ~clear;
	assign tick    = clk_rise & ~pins_sync_r.enable;

	genvar g;
	generate
		for (g = 0; g < CELL_COUNT; g++) begin : g_cell
			reg_cell u_cell (
				.clk_i        (clk_i),
				.clear_i      (clear),
				.load_en_i    (load_en),
				.load_sel_i   (pins_sync_r.select),
				.load_level_i (pins_sync_r.level[g]),
				.tick_i       (tick),
				.next0_i      (next0_r[g]),
				.next1_i      (next1_r[g]),
				.reg0_o       (bank0[g]),
				.reg1_o       (bank1[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// output pins
	// ----------------------------------------------------------------
	logic [CELL_COUNT-1:0] out_pin_r;

	// register 0 drives the pin through the programmed polarity
	always_ff @(posedge clk_i) begin
		out_pin_r <= bank0 ^ polarity_r;
	end

	assign out_pin_o  = out_pin_r;
	assign clearing_o = clear;

endmodule : preload_top

// ### verification/preload_sva.sv
module preload_sva
	import preload_pkg::*;
(
	// watched ports
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic                  pwrite_i,
	input wire logic [11:0]           paddr_i,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pready_o,
	input wire logic                  pslverr_o,
	input wire logic [CELL_COUNT-1:0] out_pin_o,
	input wire logic                  clearing_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	// cycles since reset release, saturating
	always_comb cnt_nxt = rst_i ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
	always_ff @(posedge clk_i) cnt_r <= cnt_nxt;
	sequence s_access;
		psel_i && penable_i;
	endsequence
	sequence s_stat;
		psel_i && !penable_i && !pwrite_i && paddr_i == STATUS_OFFSET ##1 s_access;
	endsequence
	a_ready_high: assert property (s_access |-> pready_o)
		else $error("pready low");
	// misaligned words are unmapped as well
	a_err_unmapped: assert property (s_access ##0
		(paddr_i > STATUS_OFFSET || paddr_i[1:0] != 2'h0) |-> pslverr_o)
		else $error("no error on unmapped");
	a_err_mapped: assert property (s_access ##0
		(paddr_i <= STATUS_OFFSET && paddr_i[1:0] == 2'h0) |-> !pslverr_o)
		else $error("error on mapped");
	a_status_clear: assert property (s_stat |-> prdata_o[0] == $past(clearing_o))
		else $error("status clear bit wrong");
	a_clr_first: assert property ($past(rst_i) |-> clearing_o)
		else $error("clear not started");
	a_clr_hold: assert property (cnt_r <= POWERUP_CLEAR_LAST |-> clearing_o)
		else $error("clear ended early");
	a_clr_end: assert property (cnt_r > POWERUP_CLEAR_LAST |-> !clearing_o)
		else $error("clear too long");
	a_out_cleared: assert property (clearing_o && $past(clearing_o, 3) |-> out_pin_o == CELL_CLEAR)
		else $error("pins not cleared");
endmodule : preload_sva

// ### verification/fixture_model.sv
module fixture_model
	import preload_pkg::*;
(
	// clock and status
	input  wire logic             clk_i,
	input  wire logic             clearing_i,
	// pins
	output logic                  en_o,
	output logic                  sel_o,
	output logic                  term_o,
	output logic [CELL_COUNT-1:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// fixture
	// ----
	initial begin
		en_o = 1'b0;
		sel_o = 1'b0;
		term_o = 1'b0;
		lvl_o = CELL_CLEAR;
	end
	// one clock term pulse, pins held around it
	task automatic pulse(input logic en, input logic s, input logic [CELL_COUNT-1:0] v);
		@(posedge clk_i);
		while (clearing_i !== 1'b0) @(posedge clk_i);
		en_o <= en;
		sel_o <= s;
		lvl_o <= v;
		repeat (5) @(posedge clk_i);
		term_o <= 1'b1;
		repeat (5) @(posedge clk_i);
		term_o <= 1'b0;
		repeat (5) @(posedge clk_i);
		en_o <= 1'b0;
		lvl_o <= ~v; // released pins drift
	endtask : pulse
	// hold the enable alone, no clock term, until it is synchronised
	task automatic hold_en(input logic en);
		@(posedge clk_i);
		en_o <= en;
		repeat (3) @(posedge clk_i);
	endtask : hold_en
endmodule : fixture_model

// ### verification/preload_top_tb.sv
module preload_top_tb
	import preload_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// bench
	// ----
	logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = DATA_ZERO, prdata_o, q;
	logic pready_o, pslverr_o, clearing_o, en, sel, term, e;
	logic [CELL_COUNT-1:0] lvl, out_pin_o;
	int n_mismatch = 0, compares = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	preload_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .preload_en_i(en), .select_i(sel),
		.clock_term_i(term), .io_level_i(lvl), .out_pin_o(out_pin_o), .clearing_o(clearing_o));
	fixture_model i_fix (.clk_i(clk_i), .clearing_i(clearing_o), .en_o(en), .sel_o(sel),
		.term_o(term), .lvl_o(lvl));
	task automatic end_sim;
		if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// ends once pready is high; the bench timeout ends it if pready never rises
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, DATA_ZERO);
		chk(q, x);
	endtask : rd
	task automatic t_powerup;
		int k;
		rd(STATUS_OFFSET, 32'h00000001);
		for (k = 0; k < 400 && clearing_o !== 1'b0; k++) @(posedge clk_i);
		chk({31'h0, clearing_o}, DATA_ZERO);
		rd(REG0_OFFSET, DATA_ZERO);
		rd(REG1_OFFSET, DATA_ZERO);
		rd(POLARITY_OFFSET, DATA_ZERO);
		chk({22'h0, out_pin_o}, DATA_ZERO);
	endtask : t_powerup
	task automatic t_preload;
		apb(1'b1, POLARITY_OFFSET, 32'h000003FF);
		rd(POLARITY_OFFSET, 32'h000003FF);
		i_fix.pulse(1'b1, 1'b0, 10'h2A5);
		rd(REG0_OFFSET, 32'h000002A5);
		rd(REG1_OFFSET, DATA_ZERO);
		chk({22'h0, out_pin_o}, 32'h0000015A);
		i_fix.pulse(1'b1, 1'b1, 10'h15A);
		rd(REG1_OFFSET, 32'h0000015A);
		rd(REG0_OFFSET, 32'h000002A5);
	endtask : t_preload
	task automatic t_normal;
		apb(1'b1, NEXT0_OFFSET, 32'h000000F0);
		apb(1'b1, NEXT1_OFFSET, 32'h0000030F);
		rd(NEXT0_OFFSET, 32'h000000F0);
		rd(NEXT1_OFFSET, 32'h0000030F);
		i_fix.pulse(1'b0, 1'b0, 10'h3FF);
		rd(REG0_OFFSET, 32'h000000F0);
		rd(REG1_OFFSET, 32'h0000030F);
		i_fix.pulse(1'b1, 1'b0, 10'h001);
		rd(REG0_OFFSET, 32'h00000001);
		rd(REG1_OFFSET, 32'h0000030F);
	endtask : t_normal
	task automatic t_apb;
		apb(1'b0, 12'h018, DATA_ZERO);
		chk({31'h0, e}, 32'h00000001);
		chk(q, DATA_ZERO);
		apb(1'b1, REG0_OFFSET, 32'h000003FF);
		rd(REG0_OFFSET, 32'h00000001);
		i_fix.hold_en(1'b1);
		rd(STATUS_OFFSET, 32'h00000002);
		i_fix.hold_en(1'b0);
		rd(STATUS_OFFSET, DATA_ZERO);
		rd(REG0_OFFSET, 32'h00000001);
	endtask : t_apb
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_powerup();
		t_preload();
		t_normal();
		t_apb();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_powerup();
		end_sim();
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
endmodule : preload_top_tb
bind preload_top preload_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .out_pin_o(out_pin_o), .clearing_o(clearing_o));
